//--- hdl/gpio_pkg.sv
/*
 * Constants for the port A I/O block: register offsets, field positions,
 * reset values, edge codes and the bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package gpio_pkg;
	// printed offsets are not all multiples of four: they are register indices
	localparam logic [7:0]  IDX_EDGE_SEL   = 8'h0C;
	localparam logic [7:0]  IDX_PA_INEN    = 8'h0D;
	localparam logic [7:0]  IDX_PB_INEN    = 8'h0E;
	localparam logic [7:0]  IDX_PA_DATA    = 8'h10;
	localparam logic [7:0]  IDX_PA_DIR     = 8'h11;
	localparam logic [7:0]  IDX_PA_PULLUP  = 8'h12;
	localparam logic [7:0]  IDX_TMR_SEL    = 8'h20;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'h21;
	localparam logic [7:0]  IDX_IRQ_MASK   = 8'h22;
	localparam logic [7:0]  IDX_PIN_STATE  = 8'h23;
	localparam int          ADDR_W         = 12;

	localparam int          EDGE_T16_BIT   = 4;
	localparam int          EDGE_IRQ1_LO   = 2;
	localparam int          EDGE_IRQ0_LO   = 0;
	localparam int          OPEN_DRAIN_PIN = 5;
	localparam int          PA_INT_PIN0    = 0;
	localparam int          PA_INT_PIN1    = 4;
	localparam int          PB_INT_PIN0    = 5;
	localparam int          PB_INT_PIN1    = 0;
	localparam int          TMR_BASE_BIT   = 8;

	localparam logic [7:0]  EDGE_SEL_RESET = 8'h00;
	localparam logic [7:0]  PA_INEN_RESET  = 8'hF9;
	localparam logic [7:0]  PA_INEN_MASK   = 8'hF9;
	localparam logic [7:0]  PB_INEN_RESET  = 8'hFF;
	localparam logic [7:0]  PORT_RESET     = 8'h00;

	// status bits: 0 first pin irq, 1 second pin irq, 2 timer irq
	localparam int          NUM_IRQ        = 3;
	localparam int          IRQ_TMR        = 2;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {
		EDGE_BOTH    = 2'b00,
		EDGE_RISE    = 2'b01,
		EDGE_FALL    = 2'b10,
		EDGE_RESERVD = 2'b11
	} edge_mode_t;
endpackage

//--- hdl/edge_if.sv
/*
 * Carrier between the top and the edge detector: raw inputs in, edge pulses out.
 * Assumes one clock domain for both ends.
 */
`timescale 1ns/1ps
interface edge_if #(parameter int N = 4);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport detector (input level, output rise, output fall);
	modport user     (output level, input rise, input fall);
endinterface

//--- hdl/edge_detect.sv
/*
 * Per-bit edge detector with optional two-flop synchroniser.
 * Assumes inputs from pins are asynchronous when SYNC is set.
 */
`timescale 1ns/1ps
module edge_detect #(
	parameter int N    = 4,
	parameter bit SYNC = 1'b1
) (
	input  wire logic   sys_clk,
	input  wire logic   rst_n,
	edge_if.detector    e
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic meta;
			logic stable;
			logic prev;
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta   <= 1'b0;
					stable <= 1'b0;
					prev   <= 1'b0;
				end else begin
					meta   <= e.level[i];
					stable <= SYNC ? meta : e.level[i];
					prev   <= stable;
				end
			end
			assign e.rise[i] = stable & ~prev;
			assign e.fall[i] = ~stable & prev;
		end
	endgenerate
endmodule

//--- hdl/porta_io.sv
/*
 * Port A data, direction and pull-up control, input enables for ports A and B,
 * and the edge selection for the two pin interrupts and the counter interrupt,
 * reached over AXI4-Lite.
 * Assumes pad cells outside resolve drive from the output and enable signals,
 * and that the sixteen-bit counter value arrives on the same clock.
 */
`timescale 1ns/1ps
module porta_io
	import gpio_pkg::*;
#(
	parameter bit PIN_SEL0 = 1'b0,
	parameter bit PIN_SEL1 = 1'b0
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  porta_in,
	output logic [7:0]       porta_out,
	output logic [7:0]       porta_oe_n,
	output logic [7:0]       porta_pullup_en,
	input  wire logic [7:0]  portb_in,
	input  wire logic [15:0] sixteen_bit_counter,
	output logic [7:0]       porta_digital,
	output logic [7:0]       portb_digital,
	output logic [7:0]       porta_wake_en,
	output logic [7:0]       portb_wake_en,
	output logic             irq
);
	logic [7:0]         edge_sel;
	logic [7:0]         pa_inen;
	logic [7:0]         pb_inen;
	logic [7:0]         porta_data;
	logic [7:0]         porta_direction;
	logic [7:0]         porta_pullup;
	logic [2:0]         tmr_sel;
	logic [NUM_IRQ-1:0] irq_status;
	logic [NUM_IRQ-1:0] irq_mask;

	logic [11:0]        aw_addr;
	logic               aw_held;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               w_held;
	logic               do_write;
	logic [7:0]         w_idx;
	logic               w_hit;
	logic [7:0]         r_idx;
	logic [31:0]        next_rdata;
	logic               r_hit;

	logic [7:0]         pa_sync1;
	logic [7:0]         pa_sync2;
	logic [7:0]         pb_sync1;
	logic [7:0]         pb_sync2;
	logic               tmr_bit;
	logic [NUM_IRQ-1:0] irq_event;

	edge_if #(.N(3)) pin_edges ();

	// write channel: address and data are taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign w_idx         = aw_addr[9:2];
	assign w_hit         = (aw_addr[1:0] == 2'b00) && (aw_addr[11:10] == 2'b00) && (w_strb[0] == 1'b1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 12'h000;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= RESP_OKAY;
			if (!(w_hit && (w_idx == IDX_EDGE_SEL || w_idx == IDX_PA_INEN || w_idx == IDX_PB_INEN
				|| w_idx == IDX_PA_DATA || w_idx == IDX_PA_DIR || w_idx == IDX_PA_PULLUP
				|| w_idx == IDX_TMR_SEL || w_idx == IDX_IRQ_STATUS || w_idx == IDX_IRQ_MASK))) begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration registers; only the low byte lane carries data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_sel        <= EDGE_SEL_RESET;
			pa_inen         <= PA_INEN_RESET;
			pb_inen         <= PB_INEN_RESET;
			porta_data      <= PORT_RESET;
			porta_direction <= PORT_RESET;
			porta_pullup    <= PORT_RESET;
			tmr_sel         <= 3'h0;
			irq_mask        <= '0;
		end else if (do_write && w_hit) begin
			unique case (w_idx)
				IDX_EDGE_SEL:   edge_sel        <= w_data[7:0] & 8'h1F;
				// reserved bits kept zero whatever software writes
				IDX_PA_INEN:    pa_inen         <= w_data[7:0] & PA_INEN_MASK;
				IDX_PB_INEN:    pb_inen         <= w_data[7:0];
				IDX_PA_DATA:    porta_data      <= w_data[7:0];
				IDX_PA_DIR:     porta_direction <= w_data[7:0];
				IDX_PA_PULLUP:  porta_pullup    <= w_data[7:0];
				IDX_TMR_SEL:    tmr_sel         <= w_data[2:0];
				IDX_IRQ_MASK:   irq_mask        <= w_data[NUM_IRQ-1:0];
				default: ;
			endcase
		end
	end

	// read channel; edge select and input enables are write-only and read zero
	assign s_axi_arready = !s_axi_rvalid;
	assign r_idx         = s_axi_araddr[9:2];

	always_comb begin
		next_rdata = 32'h00000000;
		r_hit      = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[11:10] == 2'b00);
		unique case (r_idx)
			IDX_EDGE_SEL, IDX_PA_INEN, IDX_PB_INEN: next_rdata = 32'h00000000;
			IDX_PA_DATA:    next_rdata[7:0] = porta_data;
			IDX_PA_DIR:     next_rdata[7:0] = porta_direction;
			IDX_PA_PULLUP:  next_rdata[7:0] = porta_pullup;
			IDX_TMR_SEL:    next_rdata[2:0] = tmr_sel;
			IDX_IRQ_STATUS: next_rdata[NUM_IRQ-1:0] = irq_status;
			IDX_IRQ_MASK:   next_rdata[NUM_IRQ-1:0] = irq_mask;
			IDX_PIN_STATE:  next_rdata[15:0] = {portb_digital, porta_digital};
			default:        r_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= r_hit ? next_rdata : 32'h00000000;
			s_axi_rresp  <= r_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// pad control
	always_comb begin
		porta_out  = porta_data;
		porta_oe_n = ~porta_direction;
		// pin five can only sink: a one with output mode floats the pad
		porta_out[OPEN_DRAIN_PIN]  = 1'b0;
		porta_oe_n[OPEN_DRAIN_PIN] = ~(porta_direction[OPEN_DRAIN_PIN] & ~porta_data[OPEN_DRAIN_PIN]);
	end
	assign porta_pullup_en = porta_pullup & ~porta_direction;

	// pins are asynchronous; two flops before anything reads them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_sync1 <= 8'h00;
			pa_sync2 <= 8'h00;
			pb_sync1 <= 8'h00;
			pb_sync2 <= 8'h00;
		end else begin
			pa_sync1 <= porta_in;
			pa_sync2 <= pa_sync1;
			pb_sync1 <= portb_in;
			pb_sync2 <= pb_sync1;
		end
	end

	// a disabled pin reads low so it cannot wake or interrupt
	assign porta_digital = pa_sync2 & pa_inen;
	assign portb_digital = pb_sync2 & pb_inen;
	assign porta_wake_en = pa_inen;
	assign portb_wake_en = pb_inen;

	assign tmr_bit = sixteen_bit_counter[TMR_BASE_BIT + int'(tmr_sel)];

	// inputs are already synchronised, so the detector skips its meta flop
	assign pin_edges.level[0] = PIN_SEL0 ? portb_digital[PB_INT_PIN0] : porta_digital[PA_INT_PIN0];
	assign pin_edges.level[1] = PIN_SEL1 ? porta_digital[PA_INT_PIN1] : portb_digital[PB_INT_PIN1];
	assign pin_edges.level[2] = tmr_bit;

	edge_detect #(.N(3), .SYNC(1'b0)) u_edges (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.e       (pin_edges)
	);

	function automatic logic pin_hit(input logic [1:0] mode, input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		unique case (edge_mode_t'(mode))
			EDGE_BOTH:    hit = r | f;
			EDGE_RISE:    hit = r;
			EDGE_FALL:    hit = f;
			EDGE_RESERVD: hit = 1'b0;
		endcase
		return hit;
	endfunction

	assign irq_event[0] = pin_hit(edge_sel[EDGE_IRQ0_LO +: 2], pin_edges.rise[0], pin_edges.fall[0]);
	assign irq_event[1] = pin_hit(edge_sel[EDGE_IRQ1_LO +: 2], pin_edges.rise[1], pin_edges.fall[1]);
	assign irq_event[IRQ_TMR] = edge_sel[EDGE_T16_BIT] ? pin_edges.fall[2] : pin_edges.rise[2];

	// sticky flags, cleared by writing one; a new event wins over the clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else begin
			if (do_write && w_hit && w_idx == IDX_IRQ_STATUS) begin
				irq_status <= (irq_status & ~w_data[NUM_IRQ-1:0]) | irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
		end
	end

	assign irq = |(irq_status & irq_mask);
endmodule

//--- tb/porta_io_props.sv
/* Port-level assertions for porta_io, bound to it below.
   Assumes one clock and the low-active asynchronous reset. */
`timescale 1ns/1ps
module porta_io_props (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [7:0] porta_in,
	input wire logic [7:0] porta_out,
	input wire logic [7:0] porta_oe_n,
	input wire logic [7:0] porta_pullup_en,
	input wire logic [7:0] porta_digital,
	input wire logic [7:0] portb_digital,
	input wire logic [7:0] porta_wake_en,
	input wire logic [7:0] portb_wake_en
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_pa5_low_only: assert property (porta_out[5] == 1'b0)
		else $error("pin five driven high");
	chk_pull_input: assert property ((porta_pullup_en & ~porta_oe_n) == 8'h00)
		else $error("pull-up on a driven pin");
	chk_wake_reset: assert property ($rose(rst_n) |-> porta_wake_en == 8'hF9 && portb_wake_en == 8'hFF)
		else $error("input enables not set after reset");
	chk_gate_port_a: assert property ((porta_digital & ~porta_wake_en) == 8'h00)
		else $error("disabled port a pin passes input");
	chk_gate_port_b: assert property ((portb_digital & ~portb_wake_en) == 8'h00)
		else $error("disabled port b pin passes input");
	// four quiet cycles cover the two synchroniser stages with margin
	chk_sync_follow: assert property (($stable(porta_in) && $stable(porta_wake_en))[*4] |->
		porta_digital == (porta_in & porta_wake_en))
		else $error("port a input not followed");
	chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule
bind porta_io porta_io_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.porta_in(porta_in), .porta_out(porta_out), .porta_oe_n(porta_oe_n), .porta_pullup_en(porta_pullup_en),
	.porta_digital(porta_digital), .portb_digital(portb_digital), .porta_wake_en(porta_wake_en),
	.portb_wake_en(portb_wake_en));

//--- tb/pin_board.sv
/* Board side of port A: resolves each pin from the block, the board and the pull-up.
   Assumes the board drives only where ext_en is set. */
`timescale 1ns/1ps
module pin_board (
	input wire logic        sys_clk,
	input wire logic [7:0]  porta_out,
	input wire logic [7:0]  porta_oe_n,
	input wire logic [7:0]  porta_pullup_en,
	input wire logic [7:0]  ext,
	input wire logic [7:0]  ext_en,
	output logic     [7:0]  porta_in
);
	logic [7:0] flt = 8'h00;
	// an undriven pin without pull-up wanders, so no stale level is trusted
	always @(posedge sys_clk) flt <= ~flt;
	always_comb begin
		for (int b = 0; b < 8; b++)
			porta_in[b] = !porta_oe_n[b] ? porta_out[b] : ext_en[b] ? ext[b] : porta_pullup_en[b] ? 1'b1 : flt[b];
	end
endmodule

//--- tb/testbench.sv
/* Self-checking bench for porta_io over AXI4-Lite with a board model on port A.
   Assumes PIN_SEL0 and PIN_SEL1 at 0: pin irqs come from port A pin 0 and port B pin 0. */
`timescale 1ns/1ps
module testbench;
	import gpio_pkg::*;
	logic        sys_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp;
	logic [7:0]  pa_in, pa_out, pa_oe_n, pa_pu, pa_dig, pb_dig, pa_wk, pb_wk, pb_in = 0, ext = 0, ext_en = 8'hFF;
	logic [15:0] cnt = 0;
	int          fail_count = 0, samples_checked = 0;
	porta_io i_porta_io (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .porta_in(pa_in), .porta_out(pa_out),
		.porta_oe_n(pa_oe_n), .porta_pullup_en(pa_pu), .portb_in(pb_in), .sixteen_bit_counter(cnt),
		.porta_digital(pa_dig), .portb_digital(pb_dig), .porta_wake_en(pa_wk), .portb_wake_en(pb_wk), .irq(irq));
	pin_board i_pin_board (.sys_clk(sys_clk), .porta_out(pa_out), .porta_oe_n(pa_oe_n), .porta_pullup_en(pa_pu),
		.ext(ext), .ext_en(ext_en), .porta_in(pa_in));
	always #2 sys_clk = ~sys_clk;
	task cmp(input logic [7:0] g, e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("compared %0d, mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] i, d, input logic [3:0] s, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		cmp(8'(bresp), 8'(er));
	endtask
	task rd(input logic [7:0] i, e, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		cmp(rdata[7:0], e);
		cmp(8'(rresp), 8'(er));
	endtask
	task wt;
		repeat (6) @(posedge sys_clk);
	endtask
	task chk_st(input logic [7:0] e);
		rd(IDX_IRQ_STATUS, e, RESP_OKAY);
		cmp(8'(irq), 8'(e != 0));
		wr(IDX_IRQ_STATUS, 8'h07, 4'h1, RESP_OKAY);
	endtask
	task t_reset;
		cmp(pa_wk, 8'hF9);
		cmp(pb_wk, 8'hFF);
		rd(IDX_PA_DATA, 8'h00, RESP_OKAY);
		rd(IDX_PA_DIR, 8'h00, RESP_OKAY);
		rd(IDX_PA_PULLUP, 8'h00, RESP_OKAY);
		wr(IDX_IRQ_MASK, 8'h07, 4'h1, RESP_OKAY);
	endtask
	task t_regs;
		ext_en <= 8'h01;
		wr(IDX_PA_DATA, 8'hA5, 4'h1, RESP_OKAY);
		wr(IDX_PA_DIR, 8'hFF, 4'h1, RESP_OKAY);
		rd(IDX_PA_DATA, 8'hA5, RESP_OKAY);
		cmp(pa_out, 8'h85);
		cmp(pa_oe_n, 8'h20);
		wr(IDX_PA_DATA, 8'h5A, 4'h1, RESP_OKAY);
		wt;
		cmp(pa_oe_n, 8'h00);
		cmp(pa_dig, 8'h58);
		wr(IDX_PA_DIR, 8'h0F, 4'h1, RESP_OKAY);
		wr(IDX_PA_PULLUP, 8'hFF, 4'h1, RESP_OKAY);
		wt;
		cmp(pa_pu, 8'hF0);
		cmp(pa_dig, 8'hF8);
		rd(IDX_PIN_STATE, 8'hF8, RESP_OKAY);
		rd(IDX_PA_DIR, 8'h0F, RESP_OKAY);
		wr(IDX_PA_DIR, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_PA_PULLUP, 8'h00, 4'h1, RESP_OKAY);
		ext_en <= 8'hFF;
		wt;
		wr(IDX_IRQ_STATUS, 8'h07, 4'h1, RESP_OKAY);
	endtask
	task t_bus;
		rd(8'h30, 8'h00, RESP_SLVERR);
		wr(8'h30, 8'h01, 4'h1, RESP_SLVERR);
		rd(IDX_EDGE_SEL, 8'h00, RESP_OKAY);
		wr(IDX_PA_DATA, 8'hFF, 4'h0, RESP_SLVERR);
		rd(IDX_PA_DATA, 8'h5A, RESP_OKAY);
	endtask
	task pin(input int k, input logic v);
		if (k == 0)
			ext[0] <= v;
		else
			pb_in[0] <= v;
		wt;
	endtask
	task t_pins;
		for (int k = 0; k < 2; k++)
			for (int m = 0; m < 4; m++) begin
				wr(IDX_EDGE_SEL, 8'(m << (2 * k)), 4'h1, RESP_OKAY);
				pin(k, 1'b1);
				chk_st(8'((m < 2) << k));
				pin(k, 1'b0);
				chk_st(8'((m == 0 || m == 2) << k));
			end
	endtask
	task t_timer;
		wr(IDX_TMR_SEL, 8'h03, 4'h1, RESP_OKAY);
		for (int e = 0; e < 2; e++) begin
			wr(IDX_EDGE_SEL, 8'(e << EDGE_T16_BIT), 4'h1, RESP_OKAY);
			cnt <= 16'h0800;
			wt;
			chk_st(e ? 8'h00 : 8'h04);
			cnt <= 16'h0000;
			wt;
			chk_st(e ? 8'h04 : 8'h00);
		end
	endtask
	task t_gate;
		wr(IDX_EDGE_SEL, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_PA_INEN, 8'h3E, 4'h1, RESP_OKAY);
		wr(IDX_PB_INEN, 8'hFE, 4'h1, RESP_OKAY);
		cmp(pa_wk, 8'h38);
		cmp(pb_wk, 8'hFE);
		ext <= 8'hC1;
		pb_in <= 8'h21;
		wt;
		cmp(pa_dig, 8'h00);
		cmp(pb_dig, 8'h20);
		chk_st(8'h00);
		ext <= 8'h00;
		pb_in <= 8'h00;
		wt;
		wr(IDX_PA_INEN, 8'hFF, 4'h1, RESP_OKAY);
		wr(IDX_PB_INEN, 8'hFF, 4'h1, RESP_OKAY);
		cmp(pa_wk, 8'hF9);
		chk_st(8'h00);
	endtask
	task t_mask;
		wr(IDX_IRQ_MASK, 8'h00, 4'h1, RESP_OKAY);
		ext[0] <= 1'b1;
		wt;
		cmp(8'(irq), 8'h00);
		rd(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
		wr(IDX_IRQ_MASK, 8'h01, 4'h1, RESP_OKAY);
		cmp(8'(irq), 8'h01);
		wr(IDX_IRQ_STATUS, 8'h01, 4'h1, RESP_OKAY);
		cmp(8'(irq), 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_regs;
		t_bus;
		t_pins;
		t_timer;
		t_gate;
		t_mask;
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		end_of_test;
	end
endmodule
